/* File: inc/tail_decode_defines.vh */
`ifndef TAIL_DECODE_DEFINES_VH
`define TAIL_DECODE_DEFINES_VH

// ----------------------------------------------------------------------------
// opcodes handled by the tail decoder
// ----------------------------------------------------------------------------
`define OP_PREFIX       8'h9E
`define OP_TRAP         8'h83
`define OP_WAIT         8'h8F
`define OP_A_TO_FLAGS   8'h84
`define OP_FLAGS_TO_A   8'h85
`define OP_A_TO_XL      8'h97
`define OP_XL_TO_A      8'h9F
`define OP_HX_TO_SP     8'h94
`define OP_SP_TO_HX     8'h95
`define OP_PROBE_DIR    8'h3D
`define OP_PROBE_A      8'h4D
`define OP_PROBE_X      8'h5D
`define OP_PROBE_IX1    8'h6D
`define OP_PROBE_IX     8'h7D
`define OP_MOV_PP       8'h4E
`define OP_MOV_PI       8'h5E
`define OP_MOV_LP       8'h6E
`define OP_MOV_IP       8'h7E
`define OP_CMPBR_IXP    8'h71
`define OP_CMPBR_IX1P   8'h61
`define OP_LDA_LONG     8'hC6
`define OP_LDA_WIDE     8'hD6

// ----------------------------------------------------------------------------
// condition flag bit positions
// ----------------------------------------------------------------------------
`define FLG_V           7
`define FLG_H           4
`define FLG_I           3
`define FLG_N           2
`define FLG_Z           1
`define FLG_C           0
`define FLG_ONES        8'h60

// ----------------------------------------------------------------------------
// reset values and trap vector
// ----------------------------------------------------------------------------
`define RST_PC          16'h0000
`define RST_SP          16'h00FF
`define RST_FLAGS       8'h68
`define TRAP_VEC_HI     16'hFFFC
`define TRAP_VEC_LO     16'hFFFD
`define PUSH_LAST       3'h4

`endif

/* File: hw/sync2.v */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// two-stage synchroniser, clears asynchronously
// ----------------------------------------------------------------------------
module sync2 (
   // clock and reset
   input  wire i_clk,
   input  wire i_rst_n,
   // level in and out
   input  wire i_d,
   output wire o_q
);
   reg meta_q;
   reg sync_q;

   // first stage feeds only the second
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end

   assign o_q = sync_q;
endmodule // sync2

`default_nettype wire

/* File: hw/cpu_insn_tail_decode.v */
// Overview of operation
// - trap stacks pc low, pc high, x, a, flags; sp decrements; sets mask
// - after stacking, trap loads pc high then low from vector
// - wait clears mask, halts core until interrupt; other flags kept
// - probe tests a, x or memory: v cleared, n and z updated
// - post-increment mode: address is index pair, pair incremented after
// - offset post-increment: pair plus unsigned byte, pair incremented
// - indexed-to-page move reads at pair, writes page, increments pair
// - page-to-indexed move reads page, writes at pair, increments pair
// - literal move writes immediate byte to the page address that follows
// - page move takes source and destination page from instruction bytes
// - wide offset taken high then low byte, added to index pair
// - long absolute address is high byte then low byte
// - bit-test branch carries page address then signed relative offset
`timescale 1ns/1ps
`default_nettype none
`include "tail_decode_defines.vh"

module cpu_insn_tail_decode (
   // clock and reset
   input  wire        i_mclk,
   input  wire        i_rst_n,
   // interrupt request pin
   input  wire        i_irq,
   // memory bus
   input  wire [7:0]  i_mem_rdata,
   output wire [15:0] o_mem_addr,
   output wire        o_mem_rd,
   output wire        o_mem_wr,
   output wire [7:0]  o_mem_wdata,
   // core state
   output wire        o_halted,
   output wire [7:0]  o_acc,
   output wire [15:0] o_index,
   output wire [15:0] o_sp,
   output wire [15:0] o_pc,
   output wire [7:0]  o_flags
);
   // ------------------------------------------------------------------------
   // states
   // ------------------------------------------------------------------------
   localparam [2:0] ST_FETCH = 3'h0;
   localparam [2:0] ST_OPC   = 3'h1;
   localparam [2:0] ST_BYTES = 3'h2;
   localparam [2:0] ST_EXEC  = 3'h3;
   localparam [2:0] ST_RDATA = 3'h4;
   localparam [2:0] ST_PUSH  = 3'h5;
   localparam [2:0] ST_VEC   = 3'h6;
   localparam [2:0] ST_WAIT  = 3'h7;

   wire        rst_n;
   wire        irq_s;
   reg  [2:0]  st_q;
   reg  [2:0]  cnt_q;
   reg         pre_q;
   reg  [7:0]  op_q;
   reg  [7:0]  b1_q;
   reg  [7:0]  b2_q;
   reg  [7:0]  a_q;
   reg  [7:0]  x_q;
   reg  [7:0]  h_q;
   reg  [15:0] sp_q;
   reg  [15:0] pc_q;
   reg  [7:0]  ccr_q;
   reg  [15:0] addr_q;
   reg         rd_q;
   reg         wr_q;
   reg  [7:0]  wdata_q;
   reg         halted_q;
   wire [15:0] hx;
   wire [15:0] ea;
   wire [1:0]  need;

   // ------------------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------------------
   // operand bytes that follow the opcode
   function [1:0] n_opnd;
      input       pre;
      input [7:0] op;
      begin
         if (pre)
            n_opnd = 2'd1;
         else if (op[7:4] == 4'h0)
            n_opnd = 2'd2;
         else
            case (op)
               `OP_PROBE_DIR, `OP_PROBE_IX1,
               `OP_MOV_PI, `OP_MOV_IP, `OP_CMPBR_IXP: n_opnd = 2'd1;
               `OP_MOV_PP, `OP_MOV_LP, `OP_CMPBR_IX1P,
               `OP_LDA_LONG, `OP_LDA_WIDE:            n_opnd = 2'd2;
               default:                               n_opnd = 2'd0;
            endcase
      end
   endfunction

   // operand source address for each mode
   function [15:0] ea_calc;
      input        pre;
      input [7:0]  op;
      input [7:0]  b1;
      input [7:0]  b2;
      input [15:0] hx_v;
      input [15:0] sp_v;
      begin
         if (pre)
            ea_calc = sp_v + {8'h00, b1};
         else
            case (op)
               `OP_PROBE_IX1,
               `OP_CMPBR_IX1P: ea_calc = hx_v + {8'h00, b1};
               `OP_PROBE_IX,
               `OP_CMPBR_IXP,
               `OP_MOV_IP:     ea_calc = hx_v;
               `OP_LDA_LONG:   ea_calc = {b1, b2};
               `OP_LDA_WIDE:   ea_calc = {b1, b2} + hx_v;
               default:        ea_calc = {8'h00, b1};
            endcase
      end
   endfunction

   // v cleared, n and z from value, the rest kept
   function [7:0] nz_flags;
      input [7:0] f;
      input [7:0] v;
      begin
         nz_flags = {1'b0, f[6:3], v[7], (v == 8'h00), f[0]};
      end
   endfunction

   // pc plus signed offset
   function [15:0] rel;
      input [15:0] pc;
      input [7:0]  off;
      begin
         rel = pc + {{8{off[7]}}, off};
      end
   endfunction

   // ------------------------------------------------------------------------
   // reset release and interrupt pin synchronisers
   // ------------------------------------------------------------------------
   sync2 u_rst_sync (
      .i_clk   (i_mclk),
      .i_rst_n (i_rst_n),
      .i_d     (1'b1),
      .o_q     (rst_n)
   );

   sync2 u_irq_sync (
      .i_clk   (i_mclk),
      .i_rst_n (rst_n),
      .i_d     (i_irq),
      .o_q     (irq_s)
   );

   assign hx   = {h_q, x_q};
   assign ea   = ea_calc(pre_q, op_q, b1_q, b2_q, hx, sp_q);
   assign need = n_opnd(pre_q, op_q);

   // ------------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------------
   // one process owns all core state so each step stays readable
   always @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q    <= ST_FETCH;
         cnt_q   <= 3'h0;
         pre_q   <= 1'b0;
         op_q    <= 8'h00;
         b1_q    <= 8'h00;
         b2_q    <= 8'h00;
         a_q     <= 8'h00;
         x_q     <= 8'h00;
         h_q     <= 8'h00;
         sp_q    <= `RST_SP;
         pc_q    <= `RST_PC;
         ccr_q   <= `RST_FLAGS;
         addr_q  <= 16'h0000;
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         wdata_q <= 8'h00;
         halted_q <= 1'b0;
      end else begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         case (st_q)
            ST_FETCH: begin
               addr_q <= pc_q;
               rd_q   <= 1'b1;
               pc_q   <= pc_q + 16'h0001;
               pre_q  <= 1'b0;
               st_q   <= ST_OPC;
            end
            ST_OPC: begin
               op_q  <= i_mem_rdata;
               cnt_q <= 3'h0;
               if (i_mem_rdata == `OP_PREFIX && !pre_q) begin
                  pre_q  <= 1'b1;
                  addr_q <= pc_q;
                  rd_q   <= 1'b1;
                  pc_q   <= pc_q + 16'h0001;
               end else if (n_opnd(pre_q, i_mem_rdata) != 2'd0) begin
                  addr_q <= pc_q;
                  rd_q   <= 1'b1;
                  pc_q   <= pc_q + 16'h0001;
                  st_q   <= ST_BYTES;
               end else begin
                  st_q <= ST_EXEC;
               end
            end
            ST_BYTES: begin
               // first byte is high, page, offset or immediate byte, second low, page or offset
               if (cnt_q == 3'h0)
                  b1_q <= i_mem_rdata;
               else
                  b2_q <= i_mem_rdata;
               if ({1'b0, need} > cnt_q + 3'h1) begin
                  cnt_q  <= cnt_q + 3'h1;
                  addr_q <= pc_q;
                  rd_q   <= 1'b1;
                  pc_q   <= pc_q + 16'h0001;
               end else begin
                  st_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               st_q <= ST_RDATA;
               addr_q <= ea;
               rd_q   <= 1'b1;
               if (!pre_q)
                  case (op_q)
                     `OP_TRAP: begin
                        // pc already points past the opcode
                        rd_q    <= 1'b0;
                        addr_q  <= sp_q;
                        wr_q    <= 1'b1;
                        wdata_q <= pc_q[7:0];
                        sp_q    <= sp_q - 16'h0001;
                        cnt_q   <= 3'h1;
                        st_q    <= ST_PUSH;
                     end
                     `OP_WAIT: begin
                        rd_q          <= 1'b0;
                        ccr_q[`FLG_I] <= 1'b0;
                        st_q          <= ST_WAIT;
                        halted_q      <= 1'b1;
                     end
                     `OP_MOV_LP: begin
                        rd_q    <= 1'b0;
                        addr_q  <= {8'h00, b2_q};
                        wr_q    <= 1'b1;
                        wdata_q <= b1_q;
                        ccr_q   <= nz_flags(ccr_q, b1_q);
                        st_q    <= ST_FETCH;
                     end
                     `OP_A_TO_FLAGS, `OP_FLAGS_TO_A, `OP_A_TO_XL,
                     `OP_XL_TO_A, `OP_HX_TO_SP, `OP_SP_TO_HX,
                     `OP_PROBE_A, `OP_PROBE_X: begin
                        rd_q <= 1'b0;
                        st_q <= ST_FETCH;
                        case (op_q)
                           `OP_A_TO_FLAGS:
                              ccr_q <= a_q | `FLG_ONES;
                           `OP_FLAGS_TO_A: a_q <= ccr_q;
                           `OP_A_TO_XL:    x_q <= a_q;
                           `OP_XL_TO_A:    a_q <= x_q;
                           `OP_HX_TO_SP:
                              sp_q <= hx - 16'h0001;
                           `OP_SP_TO_HX:
                              {h_q, x_q} <= sp_q + 16'h0001;
                           `OP_PROBE_A:
                              ccr_q <= nz_flags(ccr_q, a_q);
                           default:
                              ccr_q <= nz_flags(ccr_q, x_q);
                        endcase
                     end
                     `OP_PROBE_DIR, `OP_PROBE_IX1, `OP_PROBE_IX,
                     `OP_MOV_PP, `OP_MOV_PI, `OP_MOV_IP,
                     `OP_CMPBR_IXP, `OP_CMPBR_IX1P,
                     `OP_LDA_LONG, `OP_LDA_WIDE: begin
                        st_q <= ST_RDATA;
                     end
                     default: begin
                        // bit-test branches read; unknown opcodes do nothing
                        rd_q <= (op_q[7:4] == 4'h0);
                        st_q <= (op_q[7:4] == 4'h0) ? ST_RDATA : ST_FETCH;
                     end
                  endcase
            end
            ST_RDATA: begin
               st_q <= ST_FETCH;
               if (pre_q)
                  ccr_q <= nz_flags(ccr_q, i_mem_rdata);
               else
                  case (op_q)
                     `OP_PROBE_DIR, `OP_PROBE_IX1, `OP_PROBE_IX:
                        ccr_q <= nz_flags(ccr_q, i_mem_rdata);
                     `OP_LDA_LONG, `OP_LDA_WIDE: begin
                        a_q   <= i_mem_rdata;
                        ccr_q <= nz_flags(ccr_q, i_mem_rdata);
                     end
                     `OP_MOV_PP, `OP_MOV_PI, `OP_MOV_IP: begin
                        wr_q    <= 1'b1;
                        wdata_q <= i_mem_rdata;
                        ccr_q   <= nz_flags(ccr_q, i_mem_rdata);
                        if (op_q == `OP_MOV_PP)
                           addr_q <= {8'h00, b2_q};
                        else if (op_q == `OP_MOV_PI)
                           addr_q <= hx;
                        else
                           addr_q <= {8'h00, b1_q};
                        if (op_q != `OP_MOV_PP)
                           {h_q, x_q} <= hx + 16'h0001;
                     end
                     `OP_CMPBR_IXP, `OP_CMPBR_IX1P: begin
                        // pair moves on after the read either way
                        {h_q, x_q} <= hx + 16'h0001;
                        if (a_q == i_mem_rdata)
                           pc_q <= rel(pc_q, (op_q == `OP_CMPBR_IXP) ?
                                             b1_q : b2_q);
                     end
                     default: begin
                        // bit n from opcode, low bit picks set or clear
                        ccr_q[`FLG_C] <= i_mem_rdata[op_q[3:1]];
                        if (i_mem_rdata[op_q[3:1]] != op_q[0])
                           pc_q <= rel(pc_q, b2_q);
                     end
                  endcase
            end
            ST_PUSH: begin
               addr_q <= sp_q;
               wr_q   <= 1'b1;
               sp_q   <= sp_q - 16'h0001;
               cnt_q  <= cnt_q + 3'h1;
               case (cnt_q)
                  3'h1:    wdata_q <= pc_q[15:8];
                  3'h2:    wdata_q <= x_q;
                  3'h3:    wdata_q <= a_q;
                  default: wdata_q <= ccr_q;
               endcase
               if (cnt_q == `PUSH_LAST) begin
                  cnt_q <= 3'h0;
                  st_q  <= ST_VEC;
               end
            end
            ST_VEC: begin
               ccr_q[`FLG_I] <= 1'b1;
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == 3'h0) begin
                  addr_q <= `TRAP_VEC_HI;
                  rd_q   <= 1'b1;
               end else if (cnt_q == 3'h1) begin
                  pc_q[15:8] <= i_mem_rdata;
                  addr_q     <= `TRAP_VEC_LO;
                  rd_q       <= 1'b1;
               end else begin
                  pc_q[7:0] <= i_mem_rdata;
                  st_q      <= ST_FETCH;
               end
            end
            ST_WAIT: begin
               // core is frozen until the synchronised request shows up
               if (irq_s) begin
                  st_q     <= ST_FETCH;
                  halted_q <= 1'b0;
               end
            end
            default: st_q <= ST_FETCH;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // outputs, all from flip-flops
   // ------------------------------------------------------------------------
   assign o_mem_addr  = addr_q;
   assign o_mem_rd    = rd_q;
   assign o_mem_wr    = wr_q;
   assign o_mem_wdata = wdata_q;
   assign o_halted    = halted_q;
   assign o_acc       = a_q;
   assign o_index     = hx;
   assign o_sp        = sp_q;
   assign o_pc        = pc_q;
   assign o_flags     = ccr_q;
endmodule // cpu_insn_tail_decode

`default_nettype wire

/* File: dv/tail_decode_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tail_decode_defines.vh"

// --------
// port checker for the tail decoder
// --------
module tail_decode_checker (
   // clock, reset and interrupt
   input wire        i_mclk,
   input wire        i_rst_n,
   input wire        i_irq,
   // memory bus
   input wire [7:0]  i_mem_rdata,
   input wire [15:0] o_mem_addr,
   input wire        o_mem_rd,
   input wire        o_mem_wr,
   input wire [7:0]  o_mem_wdata,
   // core state
   input wire        o_halted,
   input wire [7:0]  o_acc,
   input wire [15:0] o_index,
   input wire [15:0] o_sp,
   input wire [15:0] o_pc,
   input wire [7:0]  o_flags
);
   wire [15:0] addr_inc = o_mem_addr + 16'h0001;
   reg         rd_q;
   reg         vd_q;
   reg [7:0]   hi_q;
   reg [7:0]   lo_q;
   // an opcode read follows an idle bus cycle and pc already points past it
   wire        op_slot = o_mem_rd && !rd_q && o_pc == addr_inc;

   // capture vector bytes as they return, so the pc load order shows
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_q <= 1'b0;
         vd_q <= 1'b0;
      end else begin
         rd_q <= o_mem_rd;
         vd_q <= o_mem_rd && o_mem_addr == `TRAP_VEC_LO;
      end
   end

   // read data stands in the strobe's own cycle, no reset needed
   always @(posedge i_mclk) begin
      if (o_mem_rd && o_mem_addr == `TRAP_VEC_HI) hi_q <= i_mem_rdata;
      if (o_mem_rd && o_mem_addr == `TRAP_VEC_LO) lo_q <= i_mem_rdata;
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   // the trap opcode answered in its own read cycle
   sequence trap_s;
      op_slot && i_mem_rdata == `OP_TRAP;
   endsequence

   a_trap_push_pc: assert property (
      trap_s |=> ##1 o_mem_wr && o_mem_wdata == $past(addr_inc[7:0], 2)
      ##1 o_mem_wr && o_mem_wdata == $past(addr_inc[15:8], 3)
      && o_mem_addr == $past(o_mem_addr) - 16'h0001)
      else $error("trap return address push wrong");
   a_trap_push_regs: assert property (
      trap_s |=> ##3 o_mem_wr && o_mem_wdata == o_index[7:0]
      ##1 o_mem_wr && o_mem_wdata == o_acc
      ##1 o_mem_wr && o_mem_wdata == o_flags
      && o_mem_addr == $past(o_mem_addr, 4) - 16'h0004)
      else $error("trap register push wrong");
   a_trap_vec_order: assert property (
      trap_s |=> ##6 o_mem_rd && o_mem_addr == `TRAP_VEC_HI
      ##1 o_mem_rd && o_mem_addr == `TRAP_VEC_LO && o_flags[`FLG_I])
      else $error("trap vector fetch or mask wrong");
   a_trap_vec_load: assert property (
      vd_q |-> o_pc == {hi_q, lo_q})
      else $error("trap vector not loaded into pc");
   a_wait_mask_clr: assert property (
      $rose(o_halted) |-> !o_flags[`FLG_I]
      && (o_flags & 8'hF7) == ($past(o_flags, 2) & 8'hF7))
      else $error("wait flags wrong");
   a_wait_halt_hold: assert property (
      o_halted && !i_irq && !$past(i_irq) && !$past(i_irq, 2) |=> o_halted)
      else $error("halt left without interrupt");
   a_wait_wake_up: assert property (
      o_halted && i_irq |-> ##[1:4] !o_halted)
      else $error("interrupt did not end halt");
   a_probe_flags: assert property (
      op_slot && i_mem_rdata == `OP_PROBE_A |=> ##1 !o_flags[`FLG_V]
      && o_flags[`FLG_N] == o_acc[7] && o_flags[`FLG_Z] == (o_acc == 8'h00)
      && o_flags[4:3] == $past(o_flags[4:3], 2)
      && o_flags[`FLG_C] == $past(o_flags[`FLG_C], 2))
      else $error("probe flags wrong");
   a_flags_to_acc: assert property (
      op_slot && i_mem_rdata == `OP_FLAGS_TO_A |=> ##1 o_acc == o_flags)
      else $error("flags copy to acc wrong");
   a_long_addr: assert property (
      op_slot && i_mem_rdata == `OP_LDA_LONG |=> ##3 o_mem_rd
      && o_mem_addr == {$past(i_mem_rdata, 3), $past(i_mem_rdata, 2)})
      else $error("long absolute address wrong");
   a_wide_addr: assert property (
      op_slot && i_mem_rdata == `OP_LDA_WIDE |=> ##3 o_mem_rd
      && o_mem_addr == {$past(i_mem_rdata, 3), $past(i_mem_rdata, 2)}
      + o_index)
      else $error("wide offset address wrong");
endmodule // tail_decode_checker

bind cpu_insn_tail_decode tail_decode_checker checker_inst (
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_irq(i_irq),
   .i_mem_rdata(i_mem_rdata), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
   .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_halted(o_halted),
   .o_acc(o_acc), .o_index(o_index), .o_sp(o_sp), .o_pc(o_pc),
   .o_flags(o_flags));
`default_nettype wire

/* File: dv/mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

// --------
// program and data memory, read data answers in the strobe's own cycle
// --------
module mem_model (
   // bus from the core
   input  wire        i_clk,
   input  wire        i_rd,
   input  wire        i_wr,
   input  wire [15:0] i_addr,
   input  wire [7:0]  i_wdata,
   // read data back
   output wire [7:0]  o_rdata
);
   reg [7:0]  mem [0:65535];
   reg [7:0]  last_q = 8'h00;
   integer    k;

   // blank cells hold a marker so stray reads change results
   initial begin
      for (k = 0; k < 65536; k = k + 1) mem[k] = 8'h5A;
   end

   // the core samples read data at the edge that ends its strobe
   always @(posedge i_clk) begin
      if (i_wr) mem[i_addr] <= i_wdata;
      if (i_rd) last_q <= mem[i_addr];
   end

   // outside a read slot show the inverse, never a stale valid byte
   assign o_rdata = i_rd ? mem[i_addr] : ~last_q;
endmodule // mem_model
`default_nettype wire

/* File: dv/cpu_insn_tail_decode_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// --------
// program driven test of the tail decoder
// --------
module cpu_insn_tail_decode_tb;
   reg         i_mclk = 1'b0;
   reg         i_rst_n = 1'b0;
   reg         i_irq = 1'b0;
   wire [7:0]  rdata, wdata, acc, flags;
   wire [15:0] addr, index, sp, pc;
   wire        rd, wr, halted;
   integer     n_errors = 0;
   integer     n_tests = 0;
   integer     cyc = 0;
   integer     k;
   reg [7:0]   prog [0:50];

   always #5 i_mclk = ~i_mclk;

   cpu_insn_tail_decode cpu_insn_tail_decode_inst (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_irq(i_irq),
      .i_mem_rdata(rdata), .o_mem_addr(addr), .o_mem_rd(rd), .o_mem_wr(wr),
      .o_mem_wdata(wdata), .o_halted(halted), .o_acc(acc), .o_index(index),
      .o_sp(sp), .o_pc(pc), .o_flags(flags));
   mem_model mem_model_inst (
      .i_clk(i_mclk), .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
      .o_rdata(rdata));

   // compare helpers, counted
   task check(input string name, input [15:0] seen, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task check8(input string name, input [7:0] seen, input [7:0] exp);
      check(name, {8'h00, seen}, {8'h00, exp});
   endtask
   function [7:0] peek(input [15:0] a);
      peek = mem_model_inst.mem[a];
   endfunction

   task close_out;
      begin
         $display("tests %0d errors %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   // each segment ends in a wait; the halt must stand with no interrupt
   task to_halt;
      integer n;
      begin
         n = 0;
         while (halted !== 1'b1 && n < 300) begin
            @(negedge i_mclk);
            n = n + 1;
         end
         check8("halt", {7'h00, halted}, 8'h01);
         repeat (8) @(negedge i_mclk);
         check8("halt hold", {7'h00, halted}, 8'h01);
      end
   endtask
   task wake;
      integer n;
      begin
         @(posedge i_mclk);
         i_irq <= 1'b1;
         n = 0;
         while (halted !== 1'b0 && n < 20) begin
            @(negedge i_mclk);
            n = n + 1;
         end
         check8("wake", {7'h00, halted}, 8'h00);
         @(posedge i_mclk);
         i_irq <= 1'b0;
      end
   endtask

   // hang guard, the whole run needs under 250 cycles
   always @(posedge i_mclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         close_out;
      end
   end

   // main sequence
   initial begin
      prog = '{8'hC6, 8'h00, 8'h80, 8'h97, 8'h4D, 8'h8F,
               8'h94, 8'hC6, 8'h00, 8'h81, 8'h97, 8'h95, 8'h8F,
               8'hD6, 8'h01, 8'h05, 8'h97, 8'hC6, 8'h00, 8'h86, 8'h84,
               8'h3D, 8'h82, 8'h85, 8'h8F,
               8'hC6, 8'h00, 8'h84, 8'h97, 8'h7E, 8'hA0, 8'h5E, 8'hA0,
               8'h6E, 8'h55, 8'hA1, 8'h4E, 8'hA1, 8'hA2, 8'h8F,
               8'h71, 8'h02, 8'h85, 8'h85, 8'h61, 8'hF0, 8'h02, 8'h85,
               8'h85, 8'h8F, 8'h83};
      #1;
      for (k = 0; k < 51; k = k + 1) mem_model_inst.mem[k] = prog[k];
      mem_model_inst.mem[16'h0080] = 8'h80;
      mem_model_inst.mem[16'h0081] = 8'h00;
      mem_model_inst.mem[16'h0082] = 8'h00;
      mem_model_inst.mem[16'h0084] = 8'h90;
      mem_model_inst.mem[16'h0086] = 8'hFF;
      mem_model_inst.mem[16'h0090] = 8'h3C;
      mem_model_inst.mem[16'h0092] = 8'h90;
      mem_model_inst.mem[16'h0183] = 8'h90;
      mem_model_inst.mem[16'h0185] = 8'h7F;
      mem_model_inst.mem[16'h009C] = 8'h00;
      mem_model_inst.mem[16'h00E0] = 8'h9E;
      mem_model_inst.mem[16'h00E1] = 8'h6D;
      mem_model_inst.mem[16'h00E2] = 8'h02;
      mem_model_inst.mem[16'h00E3] = 8'h85;
      mem_model_inst.mem[16'h00E4] = 8'h6D;
      mem_model_inst.mem[16'h00E5] = 8'h08;
      mem_model_inst.mem[16'h00E6] = 8'h8F;
      mem_model_inst.mem[16'hFFFC] = 8'h00;
      mem_model_inst.mem[16'hFFFD] = 8'hE0;
      repeat (16) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      // long load, copy to index low, probe, wait
      to_halt;
      check8("acc", acc, 8'h80);
      check("index", index, 16'h0080);
      check8("flags", flags, 8'h64);
      wake;
      // pair to stack, load zero, copy, stack to pair
      to_halt;
      check("sp", sp, 16'h007F);
      check("index", index, 16'h0080);
      check8("flags", flags, 8'h62);
      wake;
      // wide offset, flags load, memory probe, flags copy back
      to_halt;
      check("index", index, 16'h007F);
      check8("acc", acc, 8'h7B);
      check8("flags", flags, 8'h73);
      wake;
      // the four move forms
      to_halt;
      check("index", index, 16'h0092);
      check8("mem a0", peek(16'h00A0), 8'h3C);
      check8("mem 91", peek(16'h0091), 8'h3C);
      check8("mem a1", peek(16'h00A1), 8'h55);
      check8("mem a2", peek(16'h00A2), 8'h55);
      check8("flags", flags, 8'h71);
      wake;
      // compare-and-branch through both post-increment modes
      to_halt;
      check8("acc", acc, 8'h90);
      check("index", index, 16'h0094);
      wake;
      // trap: frame on the stack; target probes stack and memory, then waits
      to_halt;
      check("sp", sp, 16'h007A);
      check8("ret low", peek(16'h007F), 8'h33);
      check8("ret high", peek(16'h007E), 8'h00);
      check8("push x", peek(16'h007D), 8'h94);
      check8("push a", peek(16'h007C), 8'h90);
      check8("mask", acc & 8'h08, 8'h08);
      check8("push flags", peek(16'h007B), 8'h71);
      check8("acc", acc, 8'h7D);
      check8("flags", flags, 8'h73);
      check("pc", pc, 16'h00E7);
      close_out;
   end
endmodule // cpu_insn_tail_decode_tb
`default_nettype wire
